// *** hdl/lcg_regs.svh ***
// Register offsets, field positions and reset values of the logic cell input stage
`ifndef LCG_REGS_SVH
`define LCG_REGS_SVH

// Word indexes on the register bus; byte address is four times the index
`define LCG_IDX_CTRL       4'h0
`define LCG_IDX_POL        4'h1
`define LCG_IDX_SEL0       4'h2
`define LCG_IDX_SEL3       4'h5
`define LCG_IDX_GLS0       4'h6
`define LCG_IDX_GLS3       4'h9

// Control register fields
`define LCG_CTRL_EN_BIT    7
`define LCG_CTRL_OUT_BIT   5
`define LCG_CTRL_MODE_HI   2
`define LCG_CTRL_MODE_LO   0

// Polarity register fields
`define LCG_POL_OUT_BIT    7
`define LCG_POL_GATE_HI    3
`define LCG_POL_GATE_LO    0

// Data select field
`define LCG_SEL_HI         5
`define LCG_SEL_LO         0

// Sizes
`define LCG_NUM_CH         4
`define LCG_NUM_GATE       4
`define LCG_SEL_W          6
`define LCG_GLS_W          8
`define LCG_SRC_W          64
`define LCG_REG_W          8
`define LCG_DATA_W         32

// Gate-select layout: each channel owns a pair of bits, inverted form below true form
`define LCG_GLS_STRIDE     2
`define LCG_GLS_TRUE_OFS   1
`define LCG_GLS_INV_OFS    0

// Byte lane that carries every register
`define LCG_BE_LANE0       0

// Waitrequest level while the slave answers
`define LCG_ACK_WAIT       1'h0

// Reset values of fields cleared by every reset
`define LCG_RST_EN         1'h0
`define LCG_RST_MODE       3'h0
`define LCG_RST_OUT_INV    1'h0
`define LCG_RST_READDATA   32'h0000_0000
`define LCG_RST_WAIT       1'h1
`define LCG_RST_CELL       1'h0

`endif

// *** hdl/lcg_pkg.sv ***
// Types shared by the logic cell input stage and its logic core
package lcg_pkg;

    typedef enum logic [2:0] {
        LCG_FN_AND_OR  = 3'h0,
        LCG_FN_OR_XOR  = 3'h1,
        LCG_FN_AND4    = 3'h2,
        LCG_FN_SR      = 3'h3,
        LCG_FN_DFF_SR  = 3'h4,
        LCG_FN_DFF2_R  = 3'h5,
        LCG_FN_JK_R    = 3'h6,
        LCG_FN_LATCH   = 3'h7
    } lcg_fn_e;

    typedef enum logic [1:0] {
        LCG_BUS_IDLE = 2'h1,
        LCG_BUS_ACK  = 2'h2
    } lcg_bus_e;

    typedef logic [3:0] lcg_gate_t;

    typedef struct packed {
        logic q;
        logic clk_prev;
    } lcg_core_s;

    typedef struct packed {
        logic             en;
        lcg_fn_e          mode;
        logic             out_inv;
        lcg_gate_t        gate_inv;
        logic [3:0][5:0]  ch_src;
        logic [3:0][7:0]  gate_terms;
        lcg_bus_e         bus;
        logic             wait_req;
        logic [31:0]      rdata;
        logic             cell_out;
    } lcg_top_s;

endpackage

// *** hdl/lcg_cfg_if.sv ***
// Signals between the input stage and the logic core
`timescale 1ns/100ps
interface lcg_cfg_if;
    lcg_pkg::lcg_gate_t gate;
    lcg_pkg::lcg_fn_e   mode;
    logic               enable;
    logic               result;

    modport stage (output gate, output mode, output enable, input result);
    modport core  (input gate, input mode, input enable, output result);
endinterface

// *** hdl/lcg_core.sv ***
// Logic function core fed by the four polarity-adjusted gates
`timescale 1ns/100ps
module lcg_core (
    input  wire logic  clk_i,     // System clock
    input  wire logic  rst_n_i,   // Synchronous reset, active low
    lcg_cfg_if.core    cfg        // Gates, function and result
);
    lcg_pkg::lcg_core_s st_q;
    lcg_pkg::lcg_core_s st_d;
    logic               clk_rise;
    logic               comb_out;

    always_comb begin
        st_d          = st_q;
        st_d.clk_prev = cfg.gate[0];
        clk_rise      = cfg.gate[0] & ~st_q.clk_prev;
        comb_out      = 1'b0;
        case (cfg.mode)
            lcg_pkg::LCG_FN_AND_OR: begin
                comb_out = (cfg.gate[0] & cfg.gate[1]) | (cfg.gate[2] & cfg.gate[3]);
            end
            lcg_pkg::LCG_FN_OR_XOR: begin
                comb_out = (cfg.gate[0] | cfg.gate[1]) ^ (cfg.gate[2] | cfg.gate[3]);
            end
            lcg_pkg::LCG_FN_AND4: begin
                comb_out = &cfg.gate;
            end
            lcg_pkg::LCG_FN_SR: begin
                if (cfg.gate[2] | cfg.gate[3]) begin
                    st_d.q = 1'b0;
                end else if (cfg.gate[0] | cfg.gate[1]) begin
                    st_d.q = 1'b1;
                end
            end
            lcg_pkg::LCG_FN_DFF_SR: begin
                if (cfg.gate[2]) begin
                    st_d.q = 1'b0;
                end else if (cfg.gate[3]) begin
                    st_d.q = 1'b1;
                end else if (clk_rise) begin
                    st_d.q = cfg.gate[1];
                end
            end
            lcg_pkg::LCG_FN_DFF2_R: begin
                if (cfg.gate[2]) begin
                    st_d.q = 1'b0;
                end else if (clk_rise) begin
                    st_d.q = cfg.gate[1] & cfg.gate[3];
                end
            end
            lcg_pkg::LCG_FN_JK_R: begin
                if (cfg.gate[2]) begin
                    st_d.q = 1'b0;
                end else if (clk_rise) begin
                    st_d.q = (cfg.gate[1] & ~st_q.q) | (~cfg.gate[3] & st_q.q);
                end
            end
            lcg_pkg::LCG_FN_LATCH: begin
                if (cfg.gate[2]) begin
                    st_d.q = 1'b0;
                end else if (cfg.gate[3]) begin
                    st_d.q = 1'b1;
                end else if (cfg.gate[0]) begin
                    st_d.q = cfg.gate[1];
                end
            end
            default: begin
                comb_out = 1'b0;
            end
        endcase
        // Storage is emptied while the cell is off so it restarts clean
        if (!cfg.enable || !rst_n_i) begin
            st_d = '0;
        end
    end

    always_comb begin
        case (cfg.mode)
            lcg_pkg::LCG_FN_AND_OR,
            lcg_pkg::LCG_FN_OR_XOR,
            lcg_pkg::LCG_FN_AND4: cfg.result = comb_out;
            default:              cfg.result = st_d.q;
        endcase
    end

    always_ff @(posedge clk_i) begin
        st_q <= st_d;
    end
endmodule

// *** hdl/lcg_top.sv ***
// Configurable logic cell: source select, gating, polarity and register slave
`timescale 1ns/100ps
`include "lcg_regs.svh"
module lcg_top (
    input  wire logic                       REF_CLK_I,              // System clock, 20 MHz
    input  wire logic                       RESET_N_I,              // Synchronous reset, low
    input  wire logic [3:0]                 AVS_ADDRESS_I,          // Word index
    input  wire logic                       AVS_READ_I,             // Read request
    input  wire logic                       AVS_WRITE_I,            // Write request
    input  wire logic [`LCG_DATA_W-1:0]     AVS_WRITEDATA_I,        // Write data
    input  wire logic [3:0]                 AVS_BYTEENABLE_I,       // Byte lanes
    output logic      [`LCG_DATA_W-1:0]     AVS_READDATA_O,         // Read data
    output logic                            AVS_WAITREQUEST_O,      // Stall
    input  wire logic [`LCG_SRC_W-1:0]      SRC_I,                  // Candidate sources
    output logic                            CELL_OUTPUT_O           // Cell output
);

    // Whole state of the input stage and its bus slave
    lcg_pkg::lcg_top_s         st_q;
    lcg_pkg::lcg_top_s         st_d;

    // Selected data channels and the four gate outputs
    logic [`LCG_NUM_CH-1:0]    ch_val;
    lcg_pkg::lcg_gate_t        gate_raw;
    lcg_pkg::lcg_gate_t        gate_adj;

    // Bus qualifiers and the pin value before its flip-flop
    logic                      bus_req;
    logic                      wr_hit;
    logic [`LCG_REG_W-1:0]     wr_byte;
    logic                      cell_pre;

    lcg_cfg_if                 cfg_bus ();

    // True when a word index falls inside a bank of registers
    function automatic logic in_range(
        input logic [3:0] idx,
        input logic [3:0] first,
        input logic [3:0] last
    );
        return (idx >= first) && (idx <= last);
    endfunction

    // Position of a register inside its bank
    function automatic logic [1:0] bank_slot(
        input logic [3:0] idx,
        input logic [3:0] first
    );
        logic [3:0] diff;
        diff = idx - first;
        return diff[1:0];
    endfunction

    // Bank decoders shared by the read and write paths
    function automatic logic is_ctrl(input logic [3:0] idx);
        return idx == `LCG_IDX_CTRL;
    endfunction

    function automatic logic is_pol(input logic [3:0] idx);
        return idx == `LCG_IDX_POL;
    endfunction

    function automatic logic is_sel(input logic [3:0] idx);
        return in_range(idx, `LCG_IDX_SEL0, `LCG_IDX_SEL3);
    endfunction

    function automatic logic is_gls(input logic [3:0] idx);
        return in_range(idx, `LCG_IDX_GLS0, `LCG_IDX_GLS3);
    endfunction

    // True and inverted form of every channel,
    // laid out in the same bit order as a gate-select register
    function automatic logic [`LCG_GLS_W-1:0] term_avail(input logic [`LCG_NUM_CH-1:0] ch);
        logic [`LCG_GLS_W-1:0] avail;
        avail = '0;
        for (int k = 0; k < `LCG_NUM_CH; k++) begin
            avail[`LCG_GLS_STRIDE*k+`LCG_GLS_TRUE_OFS] = ch[k];
            avail[`LCG_GLS_STRIDE*k+`LCG_GLS_INV_OFS]  = ~ch[k];
        end
        return avail;
    endfunction

    // One gate: OR of the admitted terms; a cleared bit masks its term
    function automatic logic gate_or(
        input logic [`LCG_GLS_W-1:0]  terms,
        input logic [`LCG_NUM_CH-1:0] ch
    );
        return |(terms & term_avail(ch));
    endfunction

    // Cell pin value: output polarity applied, forced low while disabled
    function automatic logic cell_drive(
        input logic en,
        input logic result,
        input logic inv
    );
        return en & (result ^ inv);
    endfunction

    // Control register image: enable, live output status and function;
    // interrupt enables are not kept, there is no interrupt logic here
    function automatic logic [`LCG_REG_W-1:0] read_ctrl(input lcg_pkg::lcg_top_s s);
        logic [`LCG_REG_W-1:0] b;
        b = '0;
        b[`LCG_CTRL_EN_BIT] = s.en;
        b[`LCG_CTRL_OUT_BIT] = s.cell_out;
        b[`LCG_CTRL_MODE_HI:`LCG_CTRL_MODE_LO] = s.mode;
        return b;
    endfunction

    // Polarity register image; bits between the fields stay zero
    function automatic logic [`LCG_REG_W-1:0] read_pol(input lcg_pkg::lcg_top_s s);
        logic [`LCG_REG_W-1:0] b;
        b = '0;
        b[`LCG_POL_OUT_BIT] = s.out_inv;
        b[`LCG_POL_GATE_HI:`LCG_POL_GATE_LO] = s.gate_inv;
        return b;
    endfunction

    // Data select image; the two top bits stay zero
    function automatic logic [`LCG_REG_W-1:0] read_sel(
        input lcg_pkg::lcg_top_s s,
        input logic [1:0]        slot
    );
        logic [`LCG_REG_W-1:0] b;
        b = '0;
        b[`LCG_SEL_HI:`LCG_SEL_LO] = s.ch_src[slot];
        return b;
    endfunction

    // Gate-select image; all eight bits are implemented
    function automatic logic [`LCG_REG_W-1:0] read_gls(
        input lcg_pkg::lcg_top_s s,
        input logic [1:0]        slot
    );
        return s.gate_terms[slot];
    endfunction

    // Read data for one word index;
    // unmapped indexes and the upper byte lanes read zero
    function automatic logic [`LCG_DATA_W-1:0] reg_read(
        input lcg_pkg::lcg_top_s s,
        input logic [3:0]        idx
    );
        logic [`LCG_REG_W-1:0] b;
        b = '0;
        if (is_ctrl(idx)) begin
            b = read_ctrl(s);
        end else if (is_pol(idx)) begin
            b = read_pol(s);
        end else if (is_sel(idx)) begin
            b = read_sel(s, bank_slot(idx, `LCG_IDX_SEL0));
        end else if (is_gls(idx)) begin
            b = read_gls(s, bank_slot(idx, `LCG_IDX_GLS0));
        end
        return {{(`LCG_DATA_W-`LCG_REG_W){1'b0}}, b};
    endfunction

    // Control write: enable and function field
    function automatic lcg_pkg::lcg_top_s write_ctrl(
        input lcg_pkg::lcg_top_s     s,
        input logic [`LCG_REG_W-1:0] b
    );
        lcg_pkg::lcg_top_s n;
        n      = s;
        n.en   = b[`LCG_CTRL_EN_BIT];
        n.mode = lcg_pkg::lcg_fn_e'(b[`LCG_CTRL_MODE_HI:`LCG_CTRL_MODE_LO]);
        return n;
    endfunction

    // Polarity write: output polarity and the four gate polarities
    function automatic lcg_pkg::lcg_top_s write_pol(
        input lcg_pkg::lcg_top_s     s,
        input logic [`LCG_REG_W-1:0] b
    );
        lcg_pkg::lcg_top_s n;
        n          = s;
        n.out_inv  = b[`LCG_POL_OUT_BIT];
        n.gate_inv = b[`LCG_POL_GATE_HI:`LCG_POL_GATE_LO];
        return n;
    endfunction

    // Data select write; only the six low bits are kept
    function automatic lcg_pkg::lcg_top_s write_sel(
        input lcg_pkg::lcg_top_s     s,
        input logic [1:0]            slot,
        input logic [`LCG_REG_W-1:0] b
    );
        lcg_pkg::lcg_top_s n;
        n              = s;
        n.ch_src[slot] = b[`LCG_SEL_HI:`LCG_SEL_LO];
        return n;
    endfunction

    // Gate-select write; every bit admits one term
    function automatic lcg_pkg::lcg_top_s write_gls(
        input lcg_pkg::lcg_top_s     s,
        input logic [1:0]            slot,
        input logic [`LCG_REG_W-1:0] b
    );
        lcg_pkg::lcg_top_s n;
        n                  = s;
        n.gate_terms[slot] = b;
        return n;
    endfunction

    // Register image after a write of one byte to one word index;
    // writes to unmapped indexes are dropped
    function automatic lcg_pkg::lcg_top_s reg_write(
        input lcg_pkg::lcg_top_s     s,
        input logic [3:0]            idx,
        input logic [`LCG_REG_W-1:0] b
    );
        lcg_pkg::lcg_top_s n;
        n = s;
        if (is_ctrl(idx)) begin
            n = write_ctrl(s, b);
        end else if (is_pol(idx)) begin
            n = write_pol(s, b);
        end else if (is_sel(idx)) begin
            n = write_sel(s, bank_slot(idx, `LCG_IDX_SEL0), b);
        end else if (is_gls(idx)) begin
            n = write_gls(s, bank_slot(idx, `LCG_IDX_GLS0), b);
        end
        return n;
    endfunction

    // Every reset clears control, output polarity and the bus slave;
    // selections and gate polarities keep their value
    function automatic lcg_pkg::lcg_top_s apply_reset(input lcg_pkg::lcg_top_s s);
        lcg_pkg::lcg_top_s n;
        n          = s;
        n.en       = `LCG_RST_EN;
        n.mode     = lcg_pkg::lcg_fn_e'(`LCG_RST_MODE);
        n.out_inv  = `LCG_RST_OUT_INV;
        n.bus      = lcg_pkg::LCG_BUS_IDLE;
        n.wait_req = `LCG_RST_WAIT;
        n.rdata    = `LCG_RST_READDATA;
        n.cell_out = `LCG_RST_CELL;
        return n;
    endfunction

    // Bus handshake: one wait state, then the answer stands for one cycle;
    // read data are captured from the registers as they stand at the request
    function automatic lcg_pkg::lcg_top_s bus_step(
        input lcg_pkg::lcg_top_s s,
        input logic              req,
        input logic              rd,
        input logic [3:0]        idx
    );
        lcg_pkg::lcg_top_s n;
        n = s;
        case (s.bus)
            lcg_pkg::LCG_BUS_IDLE: begin
                if (req) begin
                    n.bus      = lcg_pkg::LCG_BUS_ACK;
                    n.wait_req = `LCG_ACK_WAIT;
                    if (rd) begin
                        n.rdata = reg_read(s, idx);
                    end
                end
            end
            lcg_pkg::LCG_BUS_ACK: begin
                n.bus      = lcg_pkg::LCG_BUS_IDLE;
                n.wait_req = `LCG_RST_WAIT;
                n.rdata    = `LCG_RST_READDATA;
            end
            default: begin
                n.bus      = lcg_pkg::LCG_BUS_IDLE;
                n.wait_req = `LCG_RST_WAIT;
                n.rdata    = `LCG_RST_READDATA;
            end
        endcase
        return n;
    endfunction

    // Each data channel picks one of the candidate sources
    for (genvar c = 0; c < `LCG_NUM_CH; c++) begin : g_chan
        assign ch_val[c] = SRC_I[st_q.ch_src[c]];
    end

    // Gate outputs, each with its own polarity
    for (genvar g = 0; g < `LCG_NUM_GATE; g++) begin : g_gate
        assign gate_raw[g] = gate_or(st_q.gate_terms[g], ch_val);
        assign gate_adj[g] = gate_raw[g] ^ st_q.gate_inv[g];
    end

    // Logic function core
    assign cfg_bus.gate   = gate_adj;
    assign cfg_bus.mode   = st_q.mode;
    assign cfg_bus.enable = st_q.en;

    lcg_core i_core (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RESET_N_I),
        .cfg     (cfg_bus)
    );

    // Output polarity sits after the core
    assign cell_pre = cell_drive(st_q.en, cfg_bus.result, st_q.out_inv);

    assign bus_req = AVS_READ_I || AVS_WRITE_I;
    assign wr_byte = AVS_WRITEDATA_I[`LCG_REG_W-1:0];

    // Write lands only at the edge where waitrequest is seen low
    assign wr_hit = (st_q.bus == lcg_pkg::LCG_BUS_ACK) && AVS_WRITE_I
        && AVS_BYTEENABLE_I[`LCG_BE_LANE0];

    // Next state: bus handshake, register writes, output and reset
    always_comb begin
        st_d = bus_step(st_q, bus_req, AVS_READ_I, AVS_ADDRESS_I);
        // Register update from an accepted write
        if (wr_hit) begin
            st_d = reg_write(st_d, AVS_ADDRESS_I, wr_byte);
        end
        // Pin value follows the configuration one cycle later
        st_d.cell_out = cell_pre;
        // Synchronous reset overrides only the fields that reset clears
        if (!RESET_N_I) begin
            st_d = apply_reset(st_d);
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        st_q <= st_d;
    end

    assign AVS_READDATA_O    = st_q.rdata;
    assign AVS_WAITREQUEST_O = st_q.wait_req;
    assign CELL_OUTPUT_O     = st_q.cell_out;
endmodule

// *** testbench/lcg_chk.sv ***
// Port assertions for the logic cell
`timescale 1ns/100ps
module lcg_chk (
    input wire logic        REF_CLK_I,         // Clock
    input wire logic        RESET_N_I,         // Reset
    input wire logic [3:0]  AVS_ADDRESS_I,     // Index
    input wire logic        AVS_READ_I,        // Read
    input wire logic        AVS_WRITE_I,       // Write
    input wire logic [31:0] AVS_WRITEDATA_I,   // Data in
    input wire logic [31:0] AVS_READDATA_O,    // Data out
    input wire logic        AVS_WAITREQUEST_O, // Stall
    input wire logic        CELL_OUTPUT_O      // Output
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    wire       rd = AVS_READ_I && !AVS_WAITREQUEST_O;
    wire       wr = AVS_WRITE_I && !AVS_WAITREQUEST_O;
    wire [3:0] a  = AVS_ADDRESS_I;
    wire [7:0] d  = AVS_READDATA_O[7:0];
    logic       en_q;
    logic [7:0] pol_q;
    // Copies of enable and polarity as software last wrote them
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            en_q     <= 1'h0;
            pol_q[7] <= 1'h0;
        end else if (wr && a == 4'h0) begin
            en_q <= AVS_WRITEDATA_I[7];
        end else if (wr && a == 4'h1) begin
            pol_q <= AVS_WRITEDATA_I[7:0];
        end
    end
    property p_ack; AVS_READ_I || AVS_WRITE_I |-> ##[0:8] !AVS_WAITREQUEST_O; endproperty
    a_ack: assert property (p_ack) else $error("request not answered");
    property p_pol; rd && a == 4'h1 |-> d[7] == pol_q[7] && d[6:4] == 3'h0; endproperty
    a_pol: assert property (p_pol) else $error("polarity readback wrong");
    property p_sel; rd && a inside {[4'h2:4'h5]} |-> AVS_READDATA_O[31:6] == 26'h0; endproperty
    a_sel: assert property (p_sel) else $error("select high bits set");
    property p_hi; rd |-> AVS_READDATA_O[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper lanes set");
    property p_en; rd && a == 4'h0 |-> d[7] == en_q && !d[6]; endproperty
    a_en: assert property (p_en) else $error("enable readback wrong");
    property p_st; rd && a == 4'h0 && $stable(CELL_OUTPUT_O) |-> d[5] == CELL_OUTPUT_O; endproperty
    a_st: assert property (p_st) else $error("status differs from output");
    property p_off; !en_q && !$past(en_q) |-> !CELL_OUTPUT_O; endproperty
    a_off: assert property (p_off) else $error("disabled cell drives one");
    property p_flip; wr && a == 4'h1 && AVS_WRITEDATA_I[7:0] == (pol_q ^ 8'h80) && en_q
        ##1 !AVS_WRITE_I [*2] |-> CELL_OUTPUT_O != $past(CELL_OUTPUT_O, 2); endproperty
    a_flip: assert property (p_flip) else $error("output not inverted");
    c_pol: cover property (rd && a == 4'h1);
    c_gls: cover property (wr && a == 4'h6);
    c_on: cover property (en_q && CELL_OUTPUT_O);
endmodule
bind lcg_top lcg_chk i_chk (.*);

// *** testbench/lcg_top_tb_top.sv ***
// Randomised bench for the logic cell
`timescale 1ns/100ps
module lcg_top_tb_top;
    logic        clk = 1'h0, rst_n = 1'h0, rd = 1'h0, wr = 1'h0, wt, out, e;
    logic [3:0]  adr = 4'h0, ch;
    logic [7:0]  gls, pol;
    logic [23:0] sel;
    logic [31:0] wd = 32'h0, rdata, rq;
    logic [63:0] src = 64'h0;
    int          error_cnt = 0, checked = 0, seed = 50508, cyc = 0;
    initial forever #25 clk = ~clk;
    lcg_top i_dut (.REF_CLK_I(clk), .RESET_N_I(rst_n),
        .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
        .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wt),
        .SRC_I(src), .CELL_OUTPUT_O(out));
    task automatic test_done();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        adr <= a;
        wd <= {24'h0, d};
        rd <= ~w;
        wr <= w;
        @(posedge clk);
        while (wt !== 1'h0) @(posedge clk);
        rq = rdata;
        rd <= 1'h0;
        wr <= 1'h0;
        @(posedge clk);
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Gate 0 ORs its selected terms; gates 1 to 3 stay empty and inverted, so AND4 passes it
    function automatic logic exp_out(input logic [7:0] g, p, input logic [3:0] c);
        logic [7:0] t;
        t = {c[3], ~c[3], c[2], ~c[2], c[1], ~c[1], c[0], ~c[0]};
        return (|(g & t)) ^ p[0] ^ p[7];
    endfunction
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        bus(1'h0, 4'h1, 8'h0);
        cmp(rq & 32'hFFFF_FFF0, 32'h0);
        bus(1'h0, 4'h0, 8'h0);
        cmp(rq, 32'h0);
        bus(1'h0, 4'hF, 8'h0);
        cmp(rq, 32'h0);
        for (int k = 7; k < 10; k++) bus(1'h1, 4'(k), 8'h0);
        bus(1'h1, 4'h0, 8'h82);
        for (int i = 0; i < 40; i++) begin
            sel = 24'($random(seed));
            gls = (i < 2) ? {6'h0, i[0], i[0]} : 8'($random(seed));
            pol = (8'($random(seed)) & 8'h81) | 8'h0E;
            src <= {$random(seed), $random(seed)};
            for (int k = 0; k < 4; k++) bus(1'h1, 4'(k + 2), {2'h3, sel[6*k +: 6]});
            bus(1'h1, 4'h6, gls);
            bus(1'h1, 4'h1, pol);
            repeat (3) @(posedge clk);
            for (int k = 0; k < 4; k++) ch[k] = src[sel[6*k +: 6]];
            e = exp_out(gls, pol, ch);
            cmp({31'h0, out}, {31'h0, e});
            bus(1'h0, 4'h0, 8'h0);
            cmp(rq, {24'h0, 2'h2, e, 5'h2});
            bus(1'h0, 4'(i % 4 + 2), 8'h0);
            cmp(rq, {26'h0, sel[6*(i%4) +: 6]});
            bus(1'h1, 4'h1, pol ^ 8'h80);
            repeat (3) @(posedge clk);
            cmp({31'h0, out}, {31'h0, ~e});
        end
        // Mid-run reset: control and output polarity clear, selections stay
        rst_n <= 1'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        bus(1'h0, 4'h1, 8'h0);
        cmp(rq, {28'h0, pol[3:0]});
        bus(1'h0, 4'h0, 8'h0);
        cmp(rq, 32'h0);
        bus(1'h0, 4'h5, 8'h0);
        cmp(rq, {26'h0, sel[23:18]});
        bus(1'h0, 4'h6, 8'h0);
        cmp(rq, {24'h0, gls});
        // Inverted output polarity while disabled must still give zero
        bus(1'h1, 4'h1, pol | 8'h80);
        repeat (3) @(posedge clk);
        cmp({31'h0, out}, 32'h0);
        test_done();
    end
endmodule
